// ===== phy_regs_pkg.sv
// Register map, field positions, reset values and states of the PHY port
// status and event register block. Shared by every design file.
package phy_regs_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_BASIC_CTRL = 6'h00;
  localparam logic [5:0] IDX_MODE_CTRL_STAT = 6'h1b;
  localparam logic [5:0] IDX_CABLE_LEN = 6'h1c;
  localparam logic [5:0] IDX_EVENT_FLAGS = 6'h1d;
  localparam logic [5:0] IDX_EVENT_ENABLES = 6'h1e;
  localparam logic [5:0] IDX_CHIP_RESET_CTRL = 6'h3e;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_PHY_SOFT_RESET = 15;
  localparam int POS_CHIP_PHY_RESET = 0;
  localparam int POS_XOVER_SRC = 15;
  localparam int POS_XOVER_AUTO = 14;
  localparam int POS_XOVER_STATE = 13;
  localparam int POS_SQE_OFF = 11;
  localparam int POS_FAR_END_FAULT_EN = 5;
  localparam int POS_RX_POL = 4;
  localparam int CBL_MSB = 15;
  localparam int CBL_LSB = 12;
  localparam int CBL_RSVD_MSB = 11;
  localparam int EVT_MSB = 9;
  localparam int EVT_LSB = 1;
  localparam int EVT_LINK_UP = 9;
  localparam int EVT_WAKE = 8;
  localparam int EVT_ENERGY = 7;
  localparam int EVT_AN_DONE = 6;
  localparam int EVT_REMOTE_FAULT = 5;
  localparam int EVT_LINK_DOWN = 4;
  localparam int EVT_PARTNER_ACK = 3;
  localparam int EVT_PD_FAULT = 2;
  localparam int EVT_PAGE_RX = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_CABLE_LEN = 4'h0;
  localparam logic [11:0] RST_CBL_RSVD = 12'h800;
  localparam logic [9:1] RST_EVENT = 9'h000;
  localparam logic RST_BIT = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;
  localparam logic HRESP_OKAY = 1'b0;

  // Crossover mode currently applied to the port
  typedef enum logic [1:0] {
    XOVER_STRAIGHT = 2'b00,
    XOVER_CROSS = 2'b01,
    XOVER_AUTO = 2'b10
  } xover_mode_t;

endpackage

// ===== event_flag_bit.sv
// One latched event flag: sets on an enabled event, clears on read.
// Assumes the event and read-clear strobes are one-cycle pulses on hclk.
`timescale 1ns/100ps
module event_flag_bit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reload,
  input wire logic event_pulse,
  input wire logic enable,
  input wire logic read_clear,
  output logic flag
);
  import phy_regs_pkg::*;

  logic flag_ff;

  // ----------------------------------------------------------------
  // Latch
  // ----------------------------------------------------------------
  // An event in the clearing cycle survives: set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= RST_BIT;
    end else if (reload) begin
      flag_ff <= RST_BIT;
    end else if (event_pulse && enable) begin
      flag_ff <= 1'b1;
    end else if (read_clear) begin
      flag_ff <= 1'b0;
    end
  end

  assign flag = flag_ff;

endmodule

// ===== ahb_reg_port.sv
// AHB-Lite slave front end: captures address phases, presents register
// read and write strobes. Assumes a single master and single word transfers.
`timescale 1ns/100ps
module ahb_reg_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic rd_take,
  output logic [5:0] rd_idx,
  output logic wr_take,
  output logic [5:0] wr_idx
);
  import phy_regs_pkg::*;

  logic wr_pend_ff;
  logic [5:0] wr_idx_ff;
  logic active;
  logic stall;

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  assign active = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  // Read right behind a write waits one cycle so it sees the new value
  assign stall = wr_pend_ff && hsel && !hwrite &&
                 (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout = !stall;
  assign hresp = HRESP_OKAY;
  assign rd_take = active && !hwrite && !stall;
  assign rd_idx = haddr[IDX_MSB:IDX_LSB];
  assign wr_take = wr_pend_ff;
  assign wr_idx = wr_idx_ff;

  // Size is always a word here; narrower sizes are treated as a word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 6'h00;
    end else begin
      wr_pend_ff <= active && hwrite && (hsize <= 3'h2);
      if (active && hwrite) begin
        wr_idx_ff <= haddr[IDX_MSB:IDX_LSB];
      end
    end
  end

endmodule

// ===== phy_port_status_irq_regs.sv
// Per-port PHY management registers: polarity status, crossover mode select,
// cable length report, latched event flags with enables, and reset handling.
// Assumes status inputs and straps are synchronous to hclk.
`timescale 1ns/100ps

module phy_port_status_irq_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_polarity_reversed,
  input wire logic auto_mdix_strap,
  input wire logic manual_mdix_strap,
  input wire logic fiber_mode,
  input wire logic speed_100,
  input wire logic cable_fault,
  input wire logic [3:0] cable_length_in,
  input wire logic link_status,
  input wire logic wake_event,
  input wire logic energy_detected,
  input wire logic autoneg_complete,
  input wire logic remote_fault,
  input wire logic partner_ack,
  input wire logic parallel_detect_fault,
  input wire logic page_received,
  output phy_regs_pkg::xover_mode_t xover_mode,
  output logic far_end_fault_enable,
  output logic sqe_test_off,
  output logic phy_soft_reset_pulse,
  output logic phy_irq
);
  import phy_regs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rd_take;
  logic [5:0] rd_idx;
  logic wr_take;
  logic [5:0] wr_idx;
  logic [15:0] wdata;
  logic soft_reset_req;
  logic chip_reset_req;
  logic soft_reload;
  logic chip_reload_ff;
  logic soft_reload_ff;
  logic init_pend_ff;
  logic crossover_ctrl_source_ff;
  logic crossover_auto_enable_ff;
  logic crossover_manual_state_ff;
  logic sqe_off_ff;
  logic far_end_fault_enable_ff;
  logic rx_pol_ff;
  logic [3:0] cable_length_field_ff;
  logic [11:0] cbl_rsvd_ff;
  logic [9:1] phy_event_enables_ff;
  logic [9:1] phy_event_flags;
  logic [9:1] evt_pulse;
  logic link_prev_ff;
  logic energy_prev_ff;
  logic an_prev_ff;
  logic rf_prev_ff;
  logic flags_clear;
  logic [15:0] mode_word;
  logic [15:0] cable_word;
  logic [15:0] flag_word;
  logic [15:0] enable_word;
  logic [31:0] nxt_rdata;
  logic [31:0] hrdata_ff;
  xover_mode_t nxt_xover;
  xover_mode_t xover_ff;
  logic irq_ff;

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_take(rd_take),
    .rd_idx(rd_idx),
    .wr_take(wr_take),
    .wr_idx(wr_idx)
  );

  assign wdata = hwdata[15:0];

  // ----------------------------------------------------------------
  // Reset requests
  // ----------------------------------------------------------------
  // Both request bits self-clear, so they always read back as zero
  assign soft_reset_req = wr_take && (wr_idx == IDX_BASIC_CTRL) && wdata[POS_PHY_SOFT_RESET];
  assign chip_reset_req = wr_take && (wr_idx == IDX_CHIP_RESET_CTRL) &&
                          wdata[POS_CHIP_PHY_RESET];
  // Chip reset reloads everything a soft reset does, plus the immune bits, but raises no phy_soft_reset_pulse
  assign soft_reload = soft_reload_ff || chip_reload_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_reload_ff <= 1'b0;
      chip_reload_ff <= 1'b0;
    end else begin
      soft_reload_ff <= soft_reset_req;
      chip_reload_ff <= chip_reset_req;
    end
  end

  assign phy_soft_reset_pulse = soft_reload_ff;

  // Fiber mode is a level, so it is caught after reset release, not in it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_pend_ff <= 1'b1;
    end else begin
      init_pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Soft-reset-immune crossover and test controls
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crossover_ctrl_source_ff <= RST_BIT;
      crossover_auto_enable_ff <= RST_BIT;
      crossover_manual_state_ff <= RST_BIT;
      sqe_off_ff <= RST_BIT;
    end else if (chip_reload_ff) begin
      crossover_ctrl_source_ff <= RST_BIT;
      crossover_auto_enable_ff <= RST_BIT;
      crossover_manual_state_ff <= RST_BIT;
      sqe_off_ff <= RST_BIT;
    end else if (wr_take && (wr_idx == IDX_MODE_CTRL_STAT)) begin
      crossover_ctrl_source_ff <= wdata[POS_XOVER_SRC];
      crossover_auto_enable_ff <= wdata[POS_XOVER_AUTO];
      crossover_manual_state_ff <= wdata[POS_XOVER_STATE];
      sqe_off_ff <= wdata[POS_SQE_OFF];
    end
  end

  // ----------------------------------------------------------------
  // Far-end-fault enable
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      far_end_fault_enable_ff <= RST_BIT;
    end else if (init_pend_ff || soft_reload) begin
      far_end_fault_enable_ff <= fiber_mode;
    end else if (wr_take && (wr_idx == IDX_MODE_CTRL_STAT)) begin
      far_end_fault_enable_ff <= wdata[POS_FAR_END_FAULT_EN];
    end
  end

  // ----------------------------------------------------------------
  // Crossover mode select
  // ----------------------------------------------------------------
  always_comb begin
    nxt_xover = XOVER_STRAIGHT;
    if (crossover_ctrl_source_ff) begin
      case ({crossover_auto_enable_ff, crossover_manual_state_ff})
        2'b00: nxt_xover = XOVER_STRAIGHT;
        2'b01: nxt_xover = XOVER_CROSS;
        2'b10: nxt_xover = XOVER_AUTO;
        // Forbidden pair: fall back to automatic as the safest link choice
        default: nxt_xover = XOVER_AUTO;
      endcase
    end else if (auto_mdix_strap) begin
      nxt_xover = XOVER_AUTO;
    end else if (manual_mdix_strap) begin
      nxt_xover = XOVER_CROSS;
    end else begin
      nxt_xover = XOVER_STRAIGHT;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xover_ff <= XOVER_STRAIGHT;
    end else begin
      xover_ff <= nxt_xover;
    end
  end

  // ----------------------------------------------------------------
  // Polarity and cable length status
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pol_ff <= RST_BIT;
    end else begin
      rx_pol_ff <= rx_polarity_reversed;
    end
  end

  // Zero whenever the estimate has no meaning for the current link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cable_length_field_ff <= RST_CABLE_LEN;
    end else if (soft_reload) begin
      cable_length_field_ff <= RST_CABLE_LEN;
    end else if (link_status && speed_100 && !cable_fault) begin
      cable_length_field_ff <= cable_length_in;
    end else begin
      cable_length_field_ff <= RST_CABLE_LEN;
    end
  end

  // Low bits only hold their reset value or what software wrote; nothing inside reads them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cbl_rsvd_ff <= RST_CBL_RSVD;
    end else if (soft_reload) begin
      cbl_rsvd_ff <= RST_CBL_RSVD;
    end else if (wr_take && (wr_idx == IDX_CABLE_LEN)) begin
      cbl_rsvd_ff <= wdata[CBL_RSVD_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_prev_ff <= 1'b0;
      energy_prev_ff <= 1'b0;
      an_prev_ff <= 1'b0;
      rf_prev_ff <= 1'b0;
    end else begin
      link_prev_ff <= link_status;
      energy_prev_ff <= energy_detected;
      an_prev_ff <= autoneg_complete;
      rf_prev_ff <= remote_fault;
    end
  end

  always_comb begin
    evt_pulse = RST_EVENT;
    evt_pulse[EVT_LINK_UP] = link_status && !link_prev_ff;
    evt_pulse[EVT_WAKE] = wake_event;
    evt_pulse[EVT_ENERGY] = energy_detected && !energy_prev_ff;
    evt_pulse[EVT_AN_DONE] = autoneg_complete && !an_prev_ff;
    evt_pulse[EVT_REMOTE_FAULT] = remote_fault && !rf_prev_ff;
    evt_pulse[EVT_LINK_DOWN] = !link_status && link_prev_ff;
    evt_pulse[EVT_PARTNER_ACK] = partner_ack;
    evt_pulse[EVT_PD_FAULT] = parallel_detect_fault;
    evt_pulse[EVT_PAGE_RX] = page_received;
  end

  // ----------------------------------------------------------------
  // Event enables and flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_event_enables_ff <= RST_EVENT;
    end else if (soft_reload) begin
      phy_event_enables_ff <= RST_EVENT;
    end else if (wr_take && (wr_idx == IDX_EVENT_ENABLES)) begin
      phy_event_enables_ff <= wdata[EVT_MSB:EVT_LSB];
    end
  end

  // Value is copied to the read register on this same edge, then cleared
  assign flags_clear = rd_take && (rd_idx == IDX_EVENT_FLAGS);

  genvar gi;
  generate
    for (gi = EVT_LSB; gi <= EVT_MSB; gi++) begin : g_flag
      event_flag_bit u_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .reload(soft_reload),
        .event_pulse(evt_pulse[gi]),
        .enable(phy_event_enables_ff[gi]),
        .read_clear(flags_clear),
        .flag(phy_event_flags[gi])
      );
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(phy_event_flags & phy_event_enables_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    mode_word = 16'h0000;
    mode_word[POS_XOVER_SRC] = crossover_ctrl_source_ff;
    mode_word[POS_XOVER_AUTO] = crossover_auto_enable_ff;
    mode_word[POS_XOVER_STATE] = crossover_manual_state_ff;
    mode_word[POS_SQE_OFF] = sqe_off_ff;
    mode_word[POS_FAR_END_FAULT_EN] = far_end_fault_enable_ff;
    mode_word[POS_RX_POL] = rx_pol_ff;
  end

  assign cable_word = {cable_length_field_ff, cbl_rsvd_ff};
  assign flag_word = {6'h00, phy_event_flags, 1'b0};
  assign enable_word = {6'h00, phy_event_enables_ff, 1'b0};

  always_comb begin
    case (rd_idx)
      IDX_MODE_CTRL_STAT: nxt_rdata = {16'h0000, mode_word};
      IDX_CABLE_LEN: nxt_rdata = {16'h0000, cable_word};
      IDX_EVENT_FLAGS: nxt_rdata = {16'h0000, flag_word};
      IDX_EVENT_ENABLES: nxt_rdata = {16'h0000, enable_word};
      default: nxt_rdata = RDATA_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= RDATA_ZERO;
    end else if (rd_take) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = hrdata_ff;
  assign xover_mode = xover_ff;
  assign far_end_fault_enable = far_end_fault_enable_ff;
  assign sqe_test_off = sqe_off_ff;
  assign phy_irq = irq_ff;

endmodule

// ===== phy_regs_chk_asserts.sv
// Checker for the PHY status and event register block, on its ports only.
// Assumes one AHB master, hready fed from hreadyout, straps sync to hclk.
`timescale 1ns/100ps
module phy_regs_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_polarity_reversed,
  input wire logic auto_mdix_strap,
  input wire logic manual_mdix_strap,
  input wire logic fiber_mode,
  input wire logic speed_100,
  input wire logic cable_fault,
  input wire logic [3:0] cable_length_in,
  input wire logic link_status,
  input wire logic wake_event,
  input wire logic energy_detected,
  input wire logic autoneg_complete,
  input wire logic remote_fault,
  input wire logic partner_ack,
  input wire logic parallel_detect_fault,
  input wire logic page_received,
  input wire phy_regs_pkg::xover_mode_t xover_mode,
  input wire logic far_end_fault_enable,
  input wire logic phy_irq
);
  import phy_regs_pkg::*;
  // ----------------------------------------------------------------
  // Shadow of the crossover bits
  // ----------------------------------------------------------------
  logic take, rd_flags, cable_ok, wr_pend_ff, chip_ff;
  logic [5:0] wr_idx_ff;
  logic [2:0] mdix_ff;
  xover_mode_t exp_mode;
  assign take = hsel && hready && htrans[1];
  assign rd_flags = take && !hwrite && haddr[7:2] == IDX_EVENT_FLAGS;
  assign cable_ok = link_status && speed_100 && !cable_fault;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 6'h00;
    end else if (hready) begin
      wr_pend_ff <= take && hwrite;
      wr_idx_ff <= haddr[7:2];
    end
  end
  // Soft reset leaves these bits alone, only chip reset clears them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_ff <= 1'b0;
      mdix_ff <= 3'b000;
    end else begin
      chip_ff <= wr_pend_ff && hready && wr_idx_ff == IDX_CHIP_RESET_CTRL && hwdata[0];
      if (chip_ff) begin
        mdix_ff <= 3'b000;
      end else if (wr_pend_ff && hready && wr_idx_ff == IDX_MODE_CTRL_STAT) begin
        mdix_ff <= hwdata[15:13];
      end
    end
  end
  assign exp_mode = mdix_ff[2] ? (mdix_ff[1] ? XOVER_AUTO : xover_mode_t'({1'b0, mdix_ff[0]}))
      : (auto_mdix_strap ? XOVER_AUTO : xover_mode_t'({1'b0, manual_mdix_strap}));
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_quiet;
    !(wake_event || partner_ack || parallel_detect_fault || page_received)
      && $stable(link_status) && !$rose(energy_detected) && !$rose(autoneg_complete)
      && !$rose(remote_fault);
  endsequence
  sequence s_flags_read;
    rd_flags ##0 s_quiet;
  endsequence
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("slave gave a non OKAY response");
  a_wait_short: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_fefi_default: assert property ($rose(hresetn)
      |=> far_end_fault_enable == $past(fiber_mode))
    else $error("far end fault enable default wrong");
  a_irq_clears: assert property (s_flags_read |=> ##1 !phy_irq)
    else $error("irq still high after flag read");
  a_flags_rsvd_zero: assert property (rd_flags
      |=> hrdata[15:10] == 6'h00 && !hrdata[0])
    else $error("reserved flag bits not zero");
  a_polarity_bit: assert property (take && !hwrite && haddr[7:2] == IDX_MODE_CTRL_STAT
      && $stable(rx_polarity_reversed) |=> hrdata[4] == $past(rx_polarity_reversed))
    else $error("polarity bit wrong");
  a_cable_field: assert property (take && !hwrite && haddr[7:2] == IDX_CABLE_LEN
      && $stable(cable_ok) && $stable(cable_length_in)
      |=> hrdata[15:12] == ($past(cable_ok) ? $past(cable_length_in) : 4'h0))
    else $error("cable length field wrong");
  a_xover_follow: assert property ($past(hresetn)
      |-> xover_mode == $past(exp_mode))
    else $error("crossover mode wrong");
endmodule
bind phy_port_status_irq_regs phy_regs_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .rx_polarity_reversed,
  .auto_mdix_strap, .manual_mdix_strap, .fiber_mode, .speed_100, .cable_fault,
  .cable_length_in, .link_status, .wake_event, .energy_detected, .autoneg_complete,
  .remote_fault, .partner_ack, .parallel_detect_fault, .page_received, .xover_mode,
  .far_end_fault_enable, .phy_irq);

// ===== testbench.sv
// Self-checking bench for the PHY status and event register block.
// Assumes the checker file is compiled too and binds itself to the block.
`timescale 1ns/100ps
module testbench;
  import phy_regs_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, phy_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rx_polarity_reversed, auto_mdix_strap, manual_mdix_strap, fiber_mode, speed_100;
  logic cable_fault, link_status, wake_event, energy_detected, autoneg_complete;
  logic remote_fault, partner_ack, parallel_detect_fault, page_received;
  logic far_end_fault_enable, sqe_test_off, phy_soft_reset_pulse;
  logic [3:0] cable_length_in;
  logic [15:0] rd;
  xover_mode_t xover_mode;
  int errors, n_tests;
  assign hready = hreadyout;
  phy_port_status_irq_regs dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .rx_polarity_reversed, .auto_mdix_strap,
    .manual_mdix_strap, .fiber_mode, .speed_100, .cable_fault, .cable_length_in, .link_status,
    .wake_event, .energy_detected, .autoneg_complete, .remote_fault, .partner_ack,
    .parallel_detect_fault, .page_received, .xover_mode, .far_end_fault_enable, .sqe_test_off,
    .phy_soft_reset_pulse, .phy_irq);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: pin got %b expected %b", $time, got, exp);
    end
  endtask
  // Called just after an edge; waits on hready with no assumed latency
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h00_0000, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata[15:0];
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    bus(1'b0, IDX_EVENT_FLAGS, 16'h0000);
    chk(rd, 16'h0000);
    bus(1'b0, IDX_EVENT_ENABLES, 16'h0000);
    chk(rd, 16'h0000);
    bus(1'b0, IDX_CABLE_LEN, 16'h0000);
    chk(rd, 16'h0800);
    bus(1'b0, 6'h05, 16'h0000);
    chk(rd, 16'h0000);
    chk_bit(far_end_fault_enable, 1'b0);
    bus(1'b0, IDX_MODE_CTRL_STAT, 16'h0000);
    chk_bit(rd[POS_RX_POL], 1'b0);
    rx_polarity_reversed <= 1'b1;
    @(posedge hclk);
    bus(1'b0, IDX_MODE_CTRL_STAT, 16'h0000);
    chk_bit(rd[POS_RX_POL], 1'b1);
  endtask
  task automatic fire(input int b);
    case (b)
      9: link_status <= 1'b1;
      8: wake_event <= 1'b1;
      7: energy_detected <= 1'b1;
      6: autoneg_complete <= 1'b1;
      5: remote_fault <= 1'b1;
      4: link_status <= 1'b0;
      3: partner_ack <= 1'b1;
      2: parallel_detect_fault <= 1'b1;
      default: page_received <= 1'b1;
    endcase
    @(posedge hclk);
    {wake_event, energy_detected, autoneg_complete, remote_fault} <= 4'h0;
    {partner_ack, parallel_detect_fault, page_received} <= 3'h0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic t_events;
    bus(1'b1, IDX_EVENT_ENABLES, 16'h03fe);
    for (int b = 9; b >= 1; b--) begin
      fire(b);
      chk_bit(phy_irq, 1'b1);
      bus(1'b0, IDX_EVENT_FLAGS, 16'h0000);
      chk(rd, 16'h0001 << b);
      @(posedge hclk);
      chk_bit(phy_irq, 1'b0);
      bus(1'b0, IDX_EVENT_FLAGS, 16'h0000);
      chk(rd, 16'h0000);
    end
    bus(1'b1, IDX_EVENT_ENABLES, 16'h03fc);
    fire(1);
    chk_bit(phy_irq, 1'b0);
    bus(1'b1, IDX_EVENT_FLAGS, 16'hffff);
    bus(1'b0, IDX_EVENT_FLAGS, 16'h0000);
    chk(rd, 16'h0000);
  endtask
  task automatic t_cable;
    {cable_length_in, speed_100, link_status, cable_fault} <= 7'b1010_110;
    @(posedge hclk);
    bus(1'b1, IDX_CABLE_LEN, 16'h0800);
    bus(1'b0, IDX_CABLE_LEN, 16'h0000);
    chk(rd, 16'ha800);
    cable_fault <= 1'b1;
    @(posedge hclk);
    bus(1'b0, IDX_CABLE_LEN, 16'h0000);
    chk(rd, 16'h0800);
    {speed_100, cable_fault} <= 2'b00;
    @(posedge hclk);
    bus(1'b0, IDX_CABLE_LEN, 16'h0000);
    chk(rd, 16'h0800);
  endtask
  task automatic t_xover;
    for (int s = 0; s < 4; s++) begin
      {auto_mdix_strap, manual_mdix_strap} <= 2'(s);
      repeat (2) @(posedge hclk);
      chk(16'(xover_mode), s[1] ? 16'(XOVER_AUTO) : 16'(s[0]));
    end
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, IDX_MODE_CTRL_STAT, {1'b1, 2'(m), 13'h0800});
      repeat (2) @(posedge hclk);
      chk(16'(xover_mode), 16'(m));
    end
    {auto_mdix_strap, manual_mdix_strap, fiber_mode} <= 3'b001;
    bus(1'b1, IDX_EVENT_ENABLES, 16'h03fe);
    bus(1'b1, IDX_BASIC_CTRL, 16'h8000);
    @(posedge hclk);
    chk_bit(phy_soft_reset_pulse, 1'b1);
    repeat (2) @(posedge hclk);
    chk(16'(xover_mode), 16'(XOVER_AUTO));
    chk_bit(sqe_test_off, 1'b1);
    chk_bit(far_end_fault_enable, 1'b1);
    bus(1'b0, IDX_EVENT_ENABLES, 16'h0000);
    chk(rd, 16'h0000);
    bus(1'b1, IDX_CHIP_RESET_CTRL, 16'h0001);
    repeat (3) @(posedge hclk);
    chk(16'(xover_mode), 16'(XOVER_STRAIGHT));
    chk_bit(sqe_test_off, 1'b0);
  endtask
  initial begin
    errors = 0;
    n_tests = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'd2;
    {rx_polarity_reversed, auto_mdix_strap, manual_mdix_strap, fiber_mode, speed_100} = '0;
    {cable_fault, link_status, wake_event, energy_detected, autoneg_complete} = '0;
    {remote_fault, partner_ack, parallel_detect_fault, page_received, cable_length_in} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_events();
    t_cable();
    t_xover();
    tally_and_finish();
  end
  // Tests need well under 1000 cycles; allow 2500
  initial begin
    #100000;
    errors++;
    $display("wrong value at %0t: run timed out", $time);
    tally_and_finish();
  end
endmodule
